// *** src/pd_rxdet_pkg.sv ***
`default_nettype none

package pd_rxdet_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] STD_IN_OFS    = 8'h28;
   localparam logic [7:0] STD_OUT_OFS   = 8'h29;
   localparam logic [7:0] EXT_CFG_OFS   = 8'h2a;
   localparam logic [7:0] HDR_OFS       = 8'h2e;
   localparam logic [7:0] RXEN_OFS      = 8'h2f;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int         HDR_CABLE_POS = 4;
   localparam int         HDR_DATA_POS  = 3;
   localparam int         HDR_REV_LO    = 1;
   localparam int         HDR_POWER_POS = 0;
   localparam int         EXT_BIDIR_POS = 1;
   localparam int         RXEN_HARD_POS = 5;
   localparam int         RXEN_CBL_POS  = 6;
   localparam logic [4:0] HDR_RESET     = 5'h0d;  // cable 0, dfp 1, rev 10, source 1
   localparam logic [6:0] RXEN_RESET    = 7'h00;
   localparam logic [7:0] CAPS_VALUE    = 8'h00;
   localparam logic [1:0] REV_RESERVED  = 2'h3;

   // Frame kinds seen by the receiver, matching enable bit positions
   localparam logic [2:0] KIND_HARD     = 3'h5;
   localparam logic [2:0] KIND_CABLE    = 3'h6;

endpackage : pd_rxdet_pkg

`default_nettype wire

// *** src/pd_rx_kind_gate.sv ***
`timescale 1ns/10ps
`default_nettype none

// Decides whether a received frame kind is enabled and whether it earns a reply
module pd_rx_kind_gate
(
   input  wire logic [6:0] enables,
   input  wire logic [2:0] kind,
   input  wire logic       is_goodcrc,
   output logic            accepted,
   output logic            wants_reply,
   output logic            is_reset_kind
);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // per-kind enable
   always_comb
   begin
      accepted      = (kind <= 3'h6) && enables[kind];
      is_reset_kind = (kind == pd_rxdet_pkg::KIND_HARD) || (kind == pd_rxdet_pkg::KIND_CABLE);
      wants_reply   = accepted && !is_reset_kind && !is_goodcrc;
   end

endmodule : pd_rx_kind_gate

`default_nettype wire

// *** src/pd_rx_detect_header_regs.sv ***
`timescale 1ns/10ps
`default_nettype none

module pd_rx_detect_header_regs
(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            bus_error_pulse,
   input  wire logic       rx_done,
   input  wire logic [2:0] rx_kind,
   input  wire logic       rx_is_goodcrc,
   input  wire logic [4:0] rx_payload_len,
   input  wire logic       hard_reset_sent,
   input  wire logic       disconnect_seen,
   input  wire logic       one_more_cmd,
   input  wire logic       goodcrc_sent,
   output logic            goodcrc_request,
   output logic      [4:0] goodcrc_fields,
   output logic      [7:0] rx_byte_count,
   output logic      [6:0] rx_kind_enables
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0] hdr;
      logic [6:0] rxen;
      logic [7:0] count;
      logic       one_more;
      logic       reply_one_more;
      logic       reply;
      logic [7:0] rdata;
      logic       err;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic   accepted;
   logic   wants_reply;
   logic   is_reset_kind;

   pd_rx_kind_gate u_gate
   (
      .enables       (st_reg.rxen),
      .kind          (rx_kind),
      .is_goodcrc    (rx_is_goodcrc),
      .accepted      (accepted),
      .wants_reply   (wants_reply),
      .is_reset_kind (is_reset_kind)
   );

   // Read decode used for the registered read data only
   function automatic logic [7:0] read_value(input logic [7:0] a, input logic [4:0] h,
                                             input logic [6:0] e);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         pd_rxdet_pkg::STD_IN_OFS:  v = pd_rxdet_pkg::CAPS_VALUE;
         pd_rxdet_pkg::STD_OUT_OFS: v = pd_rxdet_pkg::CAPS_VALUE;
         pd_rxdet_pkg::EXT_CFG_OFS: v = 8'h00;
         pd_rxdet_pkg::HDR_OFS:     v = {3'h0, h};
         pd_rxdet_pkg::RXEN_OFS:    v = {1'b0, e};
         default:                   v = 8'h00;
      endcase
      return v;
   endfunction : read_value

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic dev_clear;
      dev_clear = 1'b0;
      st_next = st_reg;
      st_next.err = 1'b0;
      st_next.reply = 1'b0;
      if (reg_rd)
      begin
         st_next.rdata = read_value(reg_addr, st_reg.hdr, st_reg.rxen);
      end
      if (reg_wr)
      begin
         // header fields, reserved revision kept as written
         if (reg_addr == pd_rxdet_pkg::HDR_OFS)
         begin
            st_next.hdr = reg_wdata[4:0];
         end
         if (reg_addr == pd_rxdet_pkg::RXEN_OFS)
         begin
            st_next.rxen = reg_wdata[6:0];
         end
         if (reg_addr == pd_rxdet_pkg::EXT_CFG_OFS && reg_wdata[pd_rxdet_pkg::EXT_BIDIR_POS])
         begin
            st_next.err = 1'b1;
         end
      end
      if (one_more_cmd)
      begin
         st_next.one_more = 1'b1;
      end
      if (rx_done && accepted)
      begin
         st_next.count = is_reset_kind ? 8'h00 : {3'h0, rx_payload_len} + 8'h01;
         st_next.reply = wants_reply;
         // A received GoodCRC must not disarm a reply still owed to one-more
         if (wants_reply)
         begin
            st_next.reply_one_more = st_reg.one_more;
         end
      end
      if (hard_reset_sent || disconnect_seen || (rx_done && accepted && is_reset_kind) ||
          (goodcrc_sent && st_reg.reply_one_more))
      begin
         dev_clear = 1'b1;
      end
      // device clear overrides same-cycle write, so no stale enable survives
      if (dev_clear)
      begin
         st_next.rxen = pd_rxdet_pkg::RXEN_RESET;
         st_next.count = 8'h00;
         st_next.one_more = 1'b0;
         st_next.reply_one_more = 1'b0;
         st_next.reply = 1'b0;
      end
      if (st_next.rxen == 7'h00)
      begin
         st_next.one_more = 1'b0;
         st_next.reply = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         st_reg <= '0;
         st_reg.hdr <= pd_rxdet_pkg::HDR_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from flip-flops
   // reply fields are live header contents
   assign goodcrc_fields  = st_reg.hdr;
   assign goodcrc_request = st_reg.reply;
   assign reg_rdata       = st_reg.rdata;
   assign bus_error_pulse = st_reg.err;
   assign rx_byte_count   = st_reg.count;
   assign rx_kind_enables = st_reg.rxen;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_caps_zero;
      @(posedge sys_clk) disable iff (sys_rst)
      reg_rd && (reg_addr == pd_rxdet_pkg::STD_IN_OFS || reg_addr == pd_rxdet_pkg::STD_OUT_OFS ||
                 reg_addr == pd_rxdet_pkg::EXT_CFG_OFS)
         |=> reg_rdata == 8'h00;
   endproperty
   a_caps_zero: assert property (p_caps_zero) else $error("caps read nonzero");

   property p_bidir_err;
      @(posedge sys_clk) disable iff (sys_rst)
      reg_wr && reg_addr == pd_rxdet_pkg::EXT_CFG_OFS && reg_wdata[pd_rxdet_pkg::EXT_BIDIR_POS]
         |=> bus_error_pulse;
   endproperty
   a_bidir_err: assert property (p_bidir_err) else $error("bidir write no error");

   // Back-to-back bidir writes may hold the pulse high, so tie each pulse to its cause
   property p_err_cause;
      @(posedge sys_clk) disable iff (sys_rst)
      bus_error_pulse |-> $past(reg_wr && reg_addr == pd_rxdet_pkg::EXT_CFG_OFS &&
                                reg_wdata[pd_rxdet_pkg::EXT_BIDIR_POS]);
   endproperty
   a_err_cause: assert property (p_err_cause) else $error("error pulse without cause");

   property p_hdr_reset;
      @(posedge sys_clk) $fell(sys_rst) |-> goodcrc_fields == 5'h0d;
   endproperty
   a_hdr_reset: assert property (p_hdr_reset) else $error("header reset wrong");

   property p_reset_clear;
      @(posedge sys_clk) $fell(sys_rst) |-> rx_kind_enables == pd_rxdet_pkg::RXEN_RESET &&
         rx_byte_count == 8'h00 && reg_rdata == 8'h00 && !goodcrc_request && !bus_error_pulse;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");

   property p_hdr_write;
      @(posedge sys_clk) disable iff (sys_rst)
      reg_wr && reg_addr == 8'h2e |=> goodcrc_fields == $past(reg_wdata[4:0]);
   endproperty
   a_hdr_write: assert property (p_hdr_write) else $error("header not updated");

   property p_other_wr_keeps_hdr;
      @(posedge sys_clk) disable iff (sys_rst)
      reg_wr && reg_addr != pd_rxdet_pkg::HDR_OFS |=> goodcrc_fields == $past(goodcrc_fields);
   endproperty
   a_other_wr_keeps_hdr: assert property (p_other_wr_keeps_hdr) else $error("header disturbed");

   // Header reads back in place, upper bits clear
   property p_hdr_read;
      @(posedge sys_clk) disable iff (sys_rst)
      reg_rd && reg_addr == pd_rxdet_pkg::HDR_OFS
         |=> reg_rdata == {3'h0, $past(goodcrc_fields)};
   endproperty
   a_hdr_read: assert property (p_hdr_read) else $error("header read wrong");

   property p_no_reply_disabled;
      @(posedge sys_clk) disable iff (sys_rst)
      goodcrc_request |-> $past(rx_done) && $past(rx_kind_enables[rx_kind]) &&
         !$past(rx_is_goodcrc) && $past(rx_kind) < pd_rxdet_pkg::KIND_HARD;
   endproperty
   a_no_reply_disabled: assert property (p_no_reply_disabled) else $error("bad reply");

   property p_idle_no_reply;
      @(posedge sys_clk) disable iff (sys_rst)
      rx_kind_enables == pd_rxdet_pkg::RXEN_RESET |=> !goodcrc_request;
   endproperty
   a_idle_no_reply: assert property (p_idle_no_reply) else $error("reply while idle");

   property p_one_more_drop;
      @(posedge sys_clk) disable iff (sys_rst)
      rx_kind_enables == pd_rxdet_pkg::RXEN_RESET |-> !st_reg.one_more;
   endproperty
   a_one_more_drop: assert property (p_one_more_drop) else $error("one-more kept");

   property p_hard_clear;
      @(posedge sys_clk) disable iff (sys_rst)
      hard_reset_sent || disconnect_seen |=> rx_kind_enables == 7'h00 && rx_byte_count == 8'h00;
   endproperty
   a_hard_clear: assert property (p_hard_clear) else $error("enables not cleared");

   property p_one_more_clear;
      @(posedge sys_clk) disable iff (sys_rst)
      goodcrc_sent && st_reg.reply_one_more
         |=> rx_kind_enables == pd_rxdet_pkg::RXEN_RESET && rx_byte_count == 8'h00;
   endproperty
   a_one_more_clear: assert property (p_one_more_clear) else $error("one-more no clear");

   property p_rxen_write;
      @(posedge sys_clk) disable iff (sys_rst)
      reg_wr && reg_addr == pd_rxdet_pkg::RXEN_OFS && !hard_reset_sent && !disconnect_seen &&
      !(rx_done && accepted && is_reset_kind) && !(goodcrc_sent && st_reg.reply_one_more)
         |=> rx_kind_enables == $past(reg_wdata[6:0]);
   endproperty
   a_rxen_write: assert property (p_rxen_write) else $error("enables not written");

   // Device clear beats a manager write on the same edge
   property p_clear_wins;
      @(posedge sys_clk) disable iff (sys_rst)
      reg_wr && reg_addr == pd_rxdet_pkg::RXEN_OFS && (hard_reset_sent || disconnect_seen)
         |=> rx_kind_enables == pd_rxdet_pkg::RXEN_RESET;
   endproperty
   a_clear_wins: assert property (p_clear_wins) else $error("write beat clear");

   property p_count;
      @(posedge sys_clk) disable iff (sys_rst)
      rx_done && accepted && !is_reset_kind && !hard_reset_sent && !disconnect_seen &&
      !(goodcrc_sent && st_reg.reply_one_more)
         |=> rx_byte_count == $past(rx_payload_len) + 8'h01;
   endproperty
   a_count: assert property (p_count) else $error("byte count wrong");

   property p_rxen_top;
      @(posedge sys_clk) disable iff (sys_rst)
      reg_rd && reg_addr == 8'h2f |=> reg_rdata[7] == 1'b0;
   endproperty
   a_rxen_top: assert property (p_rxen_top) else $error("reserved bit set");

   property p_reset_rx_clear;
      @(posedge sys_clk) disable iff (sys_rst)
      rx_done && accepted && is_reset_kind |=> rx_kind_enables == 7'h00 ##1 !goodcrc_request;
   endproperty
   a_reset_rx_clear: assert property (p_reset_rx_clear) else $error("reset rx no clear");

   c_reply:   cover property (@(posedge sys_clk) goodcrc_request);
   c_err:     cover property (@(posedge sys_clk) bus_error_pulse);
   c_onemore: cover property (@(posedge sys_clk) goodcrc_sent && st_reg.reply_one_more);
   c_rst_rx:  cover property (@(posedge sys_clk) rx_done && accepted && is_reset_kind);
   c_clash:   cover property (@(posedge sys_clk) reg_wr && hard_reset_sent);

endmodule : pd_rx_detect_header_regs

`default_nettype wire

// *** test/pm_host.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Port manager on the register strobes
// ----------------------------------------------------------------
module pm_host
(
   input  wire logic       sys_clk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   // Idle bus at time zero
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // One-cycle strobe; released data is inverted so stale bytes never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask : wr

   // Read data is registered, so it is taken a cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask : rd

   // called only after reset, header before enables, enables last
   task automatic start_link(input logic [7:0] hdr, input logic [7:0] en);
      wr(pd_rxdet_pkg::HDR_OFS, hdr);
      wr(pd_rxdet_pkg::RXEN_OFS, en);
   endtask : start_link
endmodule : pm_host
`default_nettype wire

// *** test/pd_rx_detect_header_regs_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module pd_rx_detect_header_regs_tb;
   logic       sys_clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       reg_wr, reg_rd, bus_error_pulse, rx_done, rx_is_goodcrc, goodcrc_request;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_byte_count, rnd, v;
   logic [2:0] rx_kind;
   logic [4:0] rx_payload_len, goodcrc_fields;
   logic [6:0] rx_kind_enables;
   logic [3:0] evs;  // hard reset sent, disconnect, one-more, goodcrc sent
   int         error_cnt = 0;
   int         checked = 0;
   int         m_en, m_hdr, m_cnt, m_pend, m_arm;

   always #12.5 sys_clk = ~sys_clk;

   pm_host i_host (.sys_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
   pd_rx_detect_header_regs i_dut (.sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .bus_error_pulse, .rx_done, .rx_kind, .rx_is_goodcrc,
      .rx_payload_len, .hard_reset_sent(evs[0]), .disconnect_seen(evs[1]),
      .one_more_cmd(evs[2]), .goodcrc_sent(evs[3]), .goodcrc_request, .goodcrc_fields,
      .rx_byte_count, .rx_kind_enables);

   // ----------------------------------------------------------------
   // Checking helpers and reference model
   // ----------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   task automatic final_report;
      if (error_cnt == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Enables gone to zero by any path drop a pending one-more
   task automatic state_chk;
      if (m_en == 0)
         m_pend = 0;
      chk("enables", 8'(m_en), {1'b0, rx_kind_enables});
      chk("fields", 8'(m_hdr), {3'h0, goodcrc_fields});
      chk("count", 8'(m_cnt), rx_byte_count);
   endtask : state_chk

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      i_host.rd(a, v);
      chk("rdata", e, v);
   endtask : rdchk

   task automatic wrerr(input logic [7:0] a, input logic [7:0] d, input logic e);
      i_host.wr(a, d);
      chk("error", {7'h0, e}, {7'h0, bus_error_pulse});
      rdchk(a, 8'h00);
   endtask : wrerr

   task automatic wen(input int d);
      i_host.wr(pd_rxdet_pkg::RXEN_OFS, 8'(d));
      m_en = d & 'h7f;
      state_chk;
   endtask : wen

   task automatic frame(input int k, input int g, input int len);
      int rep;
      rep = m_en[k] && k < 5 && g == 0;
      @(negedge sys_clk);
      rx_kind = 3'(k);
      rx_is_goodcrc = 1'(g);
      rx_payload_len = 5'(len);
      rx_done = 1'b1;
      @(negedge sys_clk);
      rx_done = 1'b0;
      chk("reply", 8'(rep), {7'h0, goodcrc_request});
      if (m_en[k] && k >= 5)
      begin
         m_en = 0;
         m_cnt = 0;
         m_arm = 0;
      end
      else if (m_en[k])
      begin
         // Any accepted frame is counted, a GoodCRC too; only a reply arms one-more
         m_cnt = len + 1;
         if (rep)
            m_arm = m_pend;
      end
      state_chk;
   endtask : frame

   task automatic ev(input int i);
      @(negedge sys_clk);
      evs[i] = 1'b1;
      @(negedge sys_clk);
      evs = 4'h0;
      if (i < 2 || (i == 3 && m_arm))
      begin
         m_en = 0;
         m_cnt = 0;
      end
      if (i != 2)
         m_arm = 0;
      if (i == 2)
         m_pend = 1;
      state_chk;
   endtask : ev

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {rx_done, rx_kind, rx_is_goodcrc, rx_payload_len, evs} = '0;
      {m_en, m_cnt, m_pend, m_arm} = '0;
      m_hdr = 'h0d;
      rnd = 8'h52;
      repeat (5) @(negedge sys_clk);
      sys_rst = 1'b0;
      state_chk;
      rdchk(8'h28, 8'h00);
      rdchk(8'h29, 8'h00);
      rdchk(8'h2e, 8'h0d);
      rdchk(8'h2b, 8'h00);
      wrerr(8'h28, 8'hff, 1'b0);
      wrerr(8'h29, 8'hff, 1'b0);
      wrerr(8'h2a, 8'h02, 1'b1);
      wrerr(8'h2a, 8'h01, 1'b0);
      // Header fields, reserved revision included, upper bits discarded
      for (int i = 0; i < 8; i++)
      begin
         rnd = lfsr(rnd);
         m_hdr = (i == 0) ? 'h1f : rnd[4:0];
         i_host.wr(pd_rxdet_pkg::HDR_OFS, {3'h7, 5'(m_hdr)});
         rdchk(pd_rxdet_pkg::HDR_OFS, 8'(m_hdr));
         state_chk;
      end
      i_host.start_link(8'h0d, 8'hff);
      m_en = 'h7f;
      m_hdr = 'h0d;
      rdchk(pd_rxdet_pkg::RXEN_OFS, 8'h7f);
      // Random enable sets against random start-of-packet frames
      for (int i = 0; i < 24; i++)
      begin
         rnd = lfsr(rnd);
         if (i % 3 == 0)
            wen(rnd & 'h1f);
         rnd = lfsr(rnd);
         frame(rnd % 5, rnd[7:5] == 0, rnd % 31);
      end
      // Reset frames enabled and disabled, then device-side clear events
      for (int k = 5; k < 7; k++)
      begin
         wen('h7f);
         frame(0, 0, 4);
         frame(k, 0, 0);
         wen('h1f);
         frame(k, 0, 0);
      end
      for (int i = 0; i < 2; i++)
      begin
         wen('h7f);
         frame(1, 0, 2);
         ev(i);
      end
      wen('h01);
      ev(2);
      frame(0, 0, 6);
      ev(3);
      wen('h01);
      ev(2);
      wen('h00);
      frame(0, 0, 1);
      wen('h01);
      frame(0, 0, 1);
      ev(3);
      // Device clear and manager write on the same edge
      fork
         i_host.wr(pd_rxdet_pkg::RXEN_OFS, 8'h7f);
         ev(0);
      join
      // Second reset in mid-run must reload the header and clear the enables
      i_host.wr(pd_rxdet_pkg::HDR_OFS, 8'h12);
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      {m_en, m_cnt, m_pend, m_arm} = '0;
      m_hdr = 'h0d;
      state_chk;
      rdchk(pd_rxdet_pkg::HDR_OFS, 8'h0d);
      final_report;
   end

   // Hang guard
   initial
   begin
      #500000;
      error_cnt++;
      final_report;
   end
endmodule : pd_rx_detect_header_regs_tb
`default_nettype wire
